// >>> include/rts_pkg.sv
// constants and types shared by the reset and thermal sideband block
package rts_pkg;

    // ------------------------------------------------------------
    // widths
    // ------------------------------------------------------------
    localparam int SPEED_W = 3;
    localparam int STRAP_W = 18;
    localparam int ALERT_W = 2;

    // ------------------------------------------------------------
    // values after reset
    // ------------------------------------------------------------
    localparam logic [SPEED_W-1:0] SPEED_RST = 3'h0;
    localparam logic [STRAP_W-1:0] STRAP_RST = 18'h00000;
    localparam logic               GFX_N_RST = 1'h1;
    localparam logic               THR_RST   = 1'h0;
    localparam logic               TRIP_RST  = 1'h0;

    // ------------------------------------------------------------
    // timing: far side holds power good off for this long
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS     = 50;
    localparam int POWER_STABLE_US   = 10;
    localparam int POWER_STABLE_CYC  = (POWER_STABLE_US * 1000 + CLK_PERIOD_NS - 1)
                                       / CLK_PERIOD_NS;

    // ------------------------------------------------------------
    // sequencer states
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        ST_STRAP = 2'b00,
        ST_WAIT  = 2'b01,
        ST_RUN   = 2'b10,
        ST_TRIP  = 2'b11
    } rts_state_t;

endpackage

// >>> include/rts_strap_if.sv
// carrier for captured strap values between capture unit and sequencer
`timescale 1ns/10ps
`default_nettype none
interface rts_strap_if;
    import rts_pkg::*;

    logic [SPEED_W-1:0] speed;
    logic [STRAP_W-1:0] straps;
    logic               valid;

    modport cap (
        output speed,
        output straps,
        output valid
    );
    modport use_side (
        input speed,
        input straps,
        input valid
    );
endinterface
`default_nettype wire

// >>> logic/rts_strap_capture.sv
// strap capture unit: samples strap pins once after reset release
`timescale 1ns/10ps
`default_nettype none
module rts_strap_capture (
    input  wire logic                   clk,
    input  wire logic                   system_reset_input_n,
    input  wire logic [rts_pkg::SPEED_W-1:0] host_bus_speed_select,
    input  wire logic [rts_pkg::STRAP_W-1:0] hw_strap_pins,
    rts_strap_if.cap                    strap
);
    import rts_pkg::*;

    // ------------------------------------------------------------
    // capture at the first edge after release
    // ------------------------------------------------------------
    // pins are not taken under reset itself: an async flop may only load constants
    logic capture;
    assign capture = ~strap.valid;

    always_ff @(posedge clk or negedge system_reset_input_n) begin
        if (!system_reset_input_n) begin
            strap.valid  <= 1'b0;
            strap.speed  <= SPEED_RST;
            strap.straps <= STRAP_RST;
        end else if (capture) begin
            strap.valid  <= 1'b1;
            strap.speed  <= host_bus_speed_select;
            strap.straps <= hw_strap_pins;
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    a_strap_frozen: assert property (@(posedge clk) disable iff (!system_reset_input_n)
        $past(strap.valid) |-> $stable(strap.speed) && $stable(strap.straps))
        else $error("strap values changed after capture");
    a_speed_taken: assert property (@(posedge clk) disable iff (!system_reset_input_n)
        !strap.valid |=> strap.valid && strap.speed == $past(host_bus_speed_select))
        else $error("bus speed select not captured at release");
endmodule
`default_nettype wire

// >>> logic/rts_top.sv
// reset, power good, strap and thermal sideband sequencer
`timescale 1ns/10ps
`default_nettype none

// Summary of operation
// - system reset clears all logic asynchronously
// - bus speed select sampled at reset release
// - activity output follows graphics engine busy only in ST_RUN
// - shutdown output asserts at trip temperature
// - shutdown stops the core clock; the sequencer keeps running on clk
// - shutdown stays latched until system reset
// - reasserts after reset if still hot
// - temperature alert starts memory throttling only in ST_RUN
module rts_top (
    input  wire logic                   clk,
    input  wire logic                   system_reset_input_n,
    input  wire logic                   core_power_good,
    input  wire logic [rts_pkg::SPEED_W-1:0] host_bus_speed_select,
    input  wire logic [rts_pkg::STRAP_W-1:0] hw_strap_pins,
    input  wire logic                   graphics_engine_busy,
    input  wire logic                   junction_at_trip,
    input  wire logic [rts_pkg::ALERT_W-1:0] external_temp_alert_n,
    output logic                        graphics_activity_n,
    output logic                        thermal_shutdown_out_n,
    output logic                        thermal_shutdown_oe,
    output logic                        core_clock_run,
    output logic                        core_ready,
    output logic                        memory_throttle,
    output logic [rts_pkg::SPEED_W-1:0] expected_bus_speed,
    output logic [rts_pkg::STRAP_W-1:0] hw_straps,
    output logic                        straps_valid
);
    import rts_pkg::*;

    // ------------------------------------------------------------
    // strap capture
    // ------------------------------------------------------------
    rts_strap_if strap ();

    rts_strap_capture u_cap (
        .clk                  (clk),
        .system_reset_input_n (system_reset_input_n),
        .host_bus_speed_select(host_bus_speed_select),
        .hw_strap_pins        (hw_strap_pins),
        .strap                (strap.cap)
    );

    assign expected_bus_speed = strap.speed;
    assign hw_straps          = strap.straps;
    assign straps_valid       = strap.valid;

    // ------------------------------------------------------------
    // sequencer
    // ------------------------------------------------------------
    rts_state_t state;
    rts_state_t next_state;
    logic       tripped;
    logic       next_tripped;
    logic       running;
    logic       any_alert;

    // low alert on any sensor line asks for throttling
    function automatic logic alert_active(input logic [ALERT_W-1:0] a_n);
        alert_active = ~&a_n;
    endfunction

    assign any_alert    = alert_active(external_temp_alert_n);
    assign next_tripped = tripped | junction_at_trip;
    assign running      = (state == ST_RUN);

    always_comb begin
        next_state = state;
        case (state)
            ST_STRAP: begin
                if (strap.valid) begin
                    next_state = ST_WAIT;
                end
            end
            ST_WAIT: begin
                // power good is trusted as already stable
                if (core_power_good) begin
                    next_state = ST_RUN;
                end
            end
            ST_RUN: begin
                if (!core_power_good) begin
                    next_state = ST_WAIT;
                end
            end
            ST_TRIP: begin
                next_state = ST_TRIP;
            end
            default: begin
                next_state = ST_STRAP;
            end
        endcase
        if (junction_at_trip) begin
            next_state = ST_TRIP;
        end
    end

    // async clear; a still-hot die trips again on the first edge after release
    always_ff @(posedge clk or negedge system_reset_input_n) begin
        if (!system_reset_input_n) begin
            state   <= ST_STRAP;
            tripped <= TRIP_RST;
        end else begin
            state   <= next_state;
            tripped <= next_tripped;
        end
    end

    // ------------------------------------------------------------
    // thermal shutdown pin and clock stop
    // ------------------------------------------------------------
    // open drain: only ever drives low
    assign thermal_shutdown_out_n = 1'b0;
    assign thermal_shutdown_oe    = tripped;
    assign core_clock_run         = ~tripped;
    assign core_ready             = running;

    // ------------------------------------------------------------
    // graphics activity and memory throttle
    // ------------------------------------------------------------
    // registers below run on clk but hold their value while core_clock_run is low: they freeze on a trip
    logic next_gfx_n;
    logic next_throttle;

    assign next_gfx_n    = !core_clock_run ? graphics_activity_n
                         : running         ? ~graphics_engine_busy
                         : GFX_N_RST;
    assign next_throttle = !core_clock_run ? memory_throttle
                         : running & any_alert;

    always_ff @(posedge clk or negedge system_reset_input_n) begin
        if (!system_reset_input_n) begin
            graphics_activity_n <= GFX_N_RST;
            memory_throttle     <= THR_RST;
        end else begin
            graphics_activity_n <= next_gfx_n;
            memory_throttle     <= next_throttle;
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    sequence s_hot_trip;
        core_clock_run && junction_at_trip;
    endsequence

    sequence s_stopped;
        !core_clock_run && thermal_shutdown_oe && state == ST_TRIP;
    endsequence

    sequence s_busy_in_run;
        core_clock_run && running && graphics_engine_busy;
    endsequence

    sequence s_power_lost;
        running && !core_power_good && !junction_at_trip;
    endsequence

    sequence s_idle_core;
        core_clock_run && !running && !junction_at_trip;
    endsequence

    a_trip_asserts: assert property (@(posedge clk) disable iff (!system_reset_input_n)
        s_hot_trip |=> s_stopped)
        else $error("shutdown not raised after trip");

    a_trip_on_hot: assert property (@(posedge clk) disable iff (!system_reset_input_n)
        junction_at_trip |=> thermal_shutdown_oe)
        else $error("hot die left without shutdown");

    a_trip_latched: assert property (@(posedge clk) disable iff (!system_reset_input_n)
        thermal_shutdown_oe |=> thermal_shutdown_oe [*8])
        else $error("shutdown released without reset");

    a_clock_stop: assert property (@(posedge clk) disable iff (!system_reset_input_n)
        thermal_shutdown_oe |-> !core_clock_run && thermal_shutdown_out_n == 1'b0)
        else $error("clocks run while shutdown asserted");

    a_stop_ready: assert property (@(posedge clk) disable iff (!system_reset_input_n)
        !core_clock_run |-> !core_ready)
        else $error("core ready while clocks stopped");

    a_frozen_core: assert property (@(posedge clk) disable iff (!system_reset_input_n)
        s_stopped |=> $stable(graphics_activity_n) && $stable(memory_throttle))
        else $error("core state moved after clock stop");

    a_retrip_hot: assert property (@(posedge clk) disable iff (!system_reset_input_n)
        $rose(straps_valid) && $past(junction_at_trip) |-> thermal_shutdown_oe)
        else $error("hot die not tripped again after reset");

    a_gfx_busy: assert property (@(posedge clk) disable iff (!system_reset_input_n)
        s_busy_in_run ##1 !junction_at_trip |-> !graphics_activity_n)
        else $error("activity not shown while engine busy");

    a_gfx_idle: assert property (@(posedge clk) disable iff (!system_reset_input_n)
        core_clock_run && !graphics_engine_busy && !junction_at_trip |=> graphics_activity_n)
        else $error("activity held after engine idle");

    a_gfx_no_run: assert property (@(posedge clk) disable iff (!system_reset_input_n)
        s_idle_core |=> graphics_activity_n && !memory_throttle)
        else $error("activity or throttle shown outside run");

    a_throttle_on: assert property (@(posedge clk) disable iff (!system_reset_input_n)
        running && any_alert && !junction_at_trip |=> memory_throttle)
        else $error("alert did not start throttling");

    a_thr_off: assert property (@(posedge clk) disable iff (!system_reset_input_n)
        core_clock_run && !any_alert && !junction_at_trip |=> !memory_throttle)
        else $error("throttling held without alert");

    a_power_drop: assert property (@(posedge clk) disable iff (!system_reset_input_n)
        s_power_lost |=> !core_ready)
        else $error("core stayed ready after power good loss");

    a_wait_hold: assert property (@(posedge clk) disable iff (!system_reset_input_n)
        state == ST_WAIT && !core_power_good && !junction_at_trip |=> !core_ready)
        else $error("core ready without power good");

    a_strap_done: assert property (@(posedge clk) disable iff (!system_reset_input_n)
        state == ST_STRAP && straps_valid && !junction_at_trip |=> state == ST_WAIT)
        else $error("sequencer stuck after strap capture");

    a_release_state: assert property (@(posedge clk) disable iff (!system_reset_input_n)
        !straps_valid |-> state == ST_STRAP || state == ST_TRIP)
        else $error("sequencer not cleared by reset");
endmodule
`default_nettype wire

// >>> verification/rts_hub_model.sv
// companion hub model: power good sequencing and low power gate
`timescale 1ns/10ps
`default_nettype none
module rts_hub_model (
    input  wire logic clk,
    input  wire logic supply_ok,
    input  wire logic low_power_req,
    input  wire logic graphics_activity_n,
    output logic      core_power_good,
    output logic      low_power_go
);
    import rts_pkg::*;
    int stable_cnt = 0;
    initial core_power_good = 1'h0;
    // ------------------------------------------------------------
    // power good only once the supply has settled
    // ------------------------------------------------------------
    always @(posedge clk) begin
        stable_cnt <= supply_ok ? stable_cnt + 1 : 0;
        core_power_good <= supply_ok && (stable_cnt >= POWER_STABLE_CYC);
    end
    // no low power entry while the engine is active
    assign low_power_go = low_power_req && graphics_activity_n;
endmodule
`default_nettype wire

// >>> verification/testbench.sv
// self-checking bench for the reset and thermal sideband block
`timescale 1ns/10ps
`default_nettype none
module testbench;
    import rts_pkg::*;
    // busy, alert_n, expected activity_n, expected throttle
    typedef struct packed {
        logic       busy;
        logic [1:0] alert;
        logic       gfx_n;
        logic       thr;
    } rts_row_t;
    localparam rts_row_t ROWS [6] = '{5'h1C, 5'h0E, 5'h0B, 5'h07, 5'h11, 5'h0E};
    logic               clk = 1'h0;
    logic               system_reset_input_n = 1'h0;
    logic               core_power_good;
    logic [SPEED_W-1:0] host_bus_speed_select = 3'h5;
    logic [STRAP_W-1:0] hw_strap_pins = 18'h2A5A5;
    logic               graphics_engine_busy = 1'h0;
    logic               junction_at_trip = 1'h0;
    logic [ALERT_W-1:0] external_temp_alert_n = 2'h3;
    logic               supply_ok = 1'h0;
    logic               low_power_req = 1'h0;
    logic               graphics_activity_n, thermal_shutdown_out_n, thermal_shutdown_oe;
    logic               core_clock_run, core_ready, memory_throttle, straps_valid, low_power_go;
    logic [SPEED_W-1:0] expected_bus_speed;
    logic [STRAP_W-1:0] hw_straps;
    int                 fails = 0;
    int                 tests_run = 0;
    always #25 clk = ~clk;
    rts_top i_dut (.clk(clk), .system_reset_input_n(system_reset_input_n),
        .core_power_good(core_power_good), .host_bus_speed_select(host_bus_speed_select),
        .hw_strap_pins(hw_strap_pins), .graphics_engine_busy(graphics_engine_busy),
        .junction_at_trip(junction_at_trip), .external_temp_alert_n(external_temp_alert_n),
        .graphics_activity_n(graphics_activity_n), .thermal_shutdown_out_n(thermal_shutdown_out_n),
        .thermal_shutdown_oe(thermal_shutdown_oe), .core_clock_run(core_clock_run),
        .core_ready(core_ready), .memory_throttle(memory_throttle),
        .expected_bus_speed(expected_bus_speed), .hw_straps(hw_straps),
        .straps_valid(straps_valid));
    rts_hub_model i_hub (.clk(clk), .supply_ok(supply_ok), .low_power_req(low_power_req),
        .graphics_activity_n(graphics_activity_n), .core_power_good(core_power_good),
        .low_power_go(low_power_go));
    // ------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            fails++;
            $display("CHECK FAILED %s expected %0h seen %0h", name, exp, seen);
        end
    endtask
    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic finish_test;
        $display("checks %0d mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        step(10);
        check("gfx_n in reset", graphics_activity_n, GFX_N_RST);
        check("oe in reset", thermal_shutdown_oe, TRIP_RST);
        check("ready in reset", core_ready, 1'h0);
        check("valid in reset", straps_valid, 1'h0);
        check("pin data", thermal_shutdown_out_n, 1'h0);
        // release between edges so no edge sees a half-released block
        @(negedge clk) system_reset_input_n <= 1'h1;
        step(1);
        check("valid", straps_valid, 1'h1);
        check("speed", expected_bus_speed, 3'h5);
        check("straps", hw_straps, 18'h2A5A5);
        @(posedge clk) begin
            host_bus_speed_select <= 3'h2;
            hw_strap_pins <= 18'h0F0F0;
            supply_ok <= 1'h1;
        end
        step(2);
        check("speed held", expected_bus_speed, 3'h5);
        check("straps held", hw_straps, 18'h2A5A5);
        check("ready early", core_ready, 1'h0);
        for (int i = 0; i < 400 && core_ready !== 1'h1; i++) step(1);
        check("ready", core_ready, 1'h1);
        // ordinary cases, one row every two cycles
        foreach (ROWS[i]) begin
            @(posedge clk) begin
                graphics_engine_busy <= ROWS[i].busy;
                external_temp_alert_n <= ROWS[i].alert;
            end
            step(1);
            check("gfx_n", graphics_activity_n, ROWS[i].gfx_n);
            check("throttle", memory_throttle, ROWS[i].thr);
        end
        @(posedge clk) begin
            graphics_engine_busy <= 1'h1;
            low_power_req <= 1'h1;
        end
        step(1);
        check("low power go", low_power_go, 1'h0);
        @(posedge clk) graphics_engine_busy <= 1'h0;
        step(1);
        // trip, then cooling with activity that must stay frozen
        @(posedge clk) junction_at_trip <= 1'h1;
        step(1);
        check("oe trip", thermal_shutdown_oe, 1'h1);
        check("clk stop", core_clock_run, 1'h0);
        @(posedge clk) begin
            junction_at_trip <= 1'h0;
            graphics_engine_busy <= 1'h1;
            external_temp_alert_n <= 2'h0;
        end
        step(3);
        check("oe latched", thermal_shutdown_oe, 1'h1);
        check("gfx frozen", graphics_activity_n, 1'h1);
        check("thr frozen", memory_throttle, 1'h0);
        // mid-cycle reset while still hot
        @(posedge clk) junction_at_trip <= 1'h1;
        #10 system_reset_input_n = 1'h0;
        #5;
        check("oe async clr", thermal_shutdown_oe, 1'h0);
        check("valid async clr", straps_valid, 1'h0);
        step(2);
        @(negedge clk) system_reset_input_n <= 1'h1;
        step(1);
        check("oe again", thermal_shutdown_oe, 1'h1);
        check("speed recap", expected_bus_speed, 3'h2);
        step(1);
        check("oe hot hold", thermal_shutdown_oe, 1'h1);
        #10 system_reset_input_n = 1'h0;
        junction_at_trip = 1'h0;
        step(2);
        @(negedge clk) system_reset_input_n <= 1'h1;
        step(3);
        check("oe cool", thermal_shutdown_oe, 1'h0);
        check("clk run", core_clock_run, 1'h1);
        check("ready after cool", core_ready, 1'h1);
        // supply loss drops the core back out of run
        @(posedge clk) supply_ok <= 1'h0;
        step(3);
        check("ready lost", core_ready, 1'h0);
        check("gfx_n out of run", graphics_activity_n, 1'h1);
        check("thr out of run", memory_throttle, 1'h0);
        finish_test();
    end
    // a hang is cut short well beyond the expected run
    initial begin
        repeat (5000) @(posedge clk);
        fails++;
        finish_test();
    end
endmodule
`default_nettype wire
